// file: logic/pcp_config.sv
/*
 pcp_config: configuration register, control register reset on wake,
 fet drive gating and status bits of a battery protection monitor.
 assumes a serial front end that hands over decoded register writes
 on core_clk, and analog comparators that present levels as pins.
*/
// Contract
// - after power-up or sleep the block sleeps until the supply reaches the wake level (16V four-cell, 12V three-cell).
// - each entry into normal mode clears the whole control register.
// - while both fet control bits are zero both power fets are driven off.
// - configuration bits: 0-5 ignored, 6 charge-enable switch, 7 cell count, 8-9, 10-11, 12-13, 14-15 thresholds.
// - configuration defaults are 30C0h for four cells and 0040h for three cells.
// - the over-charge field selects 4.20V, 4.25V, 4.30V or 4.35V.
// - the under-voltage field selects 1.95-2.25V (four-cell) or 2.25-2.55V (three-cell).
// - status bit 0 is one while over-current is active or the regulator is untuned.
// - status bit 2 is low-cell or over-charge when charge-enable is on, else over-charge only.
// - the over-current field selects 0.075V, 0.100V, 0.125V or 0.150V.
// - charge-enable switch zero turns the function on; cell count one means four cells.
// - writes touch only the volatile copy; reload comes from the shadow, stored on write-enable then eeprom write.
`timescale 1ns/1ps
`default_nettype none
module pcp_config #(
   parameter bit FOUR_CELL = 1'b1,
   parameter int OV_DELAY_MS = 1000,
   parameter int UV_DELAY_MS = 1000,
   parameter int CAL_CYCLES =
      (((OV_DELAY_MS > UV_DELAY_MS) ? OV_DELAY_MS : UV_DELAY_MS)
       * (pcp_pkg::CLK_HZ / 1000)) + pcp_pkg::GUARD_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        wake_supply_level,
   input  wire logic        cfg_wr,
   input  wire logic [15:0] cfg_wdata,
   input  wire logic        ctrl_wr,
   input  wire logic [15:0] ctrl_wdata,
   input  wire logic        write_enable_cmd,
   input  wire logic        eeprom_write_cmd,
   input  wire logic        overcurrent_active,
   input  wire logic        regulator_tuned,
   input  wire logic        overcharge_flag,
   input  wire logic        lowcell_detect,
   output logic             normal_mode,
   output logic             cal_busy,
   output logic [15:0]      pack_configuration,
   output logic [15:0]      control_reg,
   output logic             charge_fet_off,
   output logic             discharge_fet_off,
   output logic [2:0]       status_bits,
   output logic [1:0]       overcharge_threshold_sel,
   output logic [1:0]       undervoltage_threshold_sel,
   output logic [1:0]       overcurrent_threshold_sel,
   output logic [1:0]       charge_enable_threshold_sel,
   output logic             cell_count_select,
   output logic             charge_enable_disable
);
   localparam logic [15:0] CFG_DEF =
      FOUR_CELL ? pcp_pkg::CFG_RST_4CELL : pcp_pkg::CFG_RST_3CELL;
   localparam int CW = $clog2(CAL_CYCLES + 1);

   default clocking d_clk @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   // three-stage sampling of asynchronous comparator levels
   logic [2:0] wake_s, oc_s, tun_s, ov_s, lc_s;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_s <= 3'h0;
         oc_s   <= 3'h0;
         tun_s  <= 3'h0;
         ov_s   <= 3'h0;
         lc_s   <= 3'h0;
      end else begin
         wake_s <= {wake_s[1:0], wake_supply_level};
         oc_s   <= {oc_s[1:0], overcurrent_active};
         tun_s  <= {tun_s[1:0], regulator_tuned};
         ov_s   <= {ov_s[1:0], overcharge_flag};
         lc_s   <= {lc_s[1:0], lowcell_detect};
      end
   end
   logic wake_q, oc_q, tun_q, ov_q, lc_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_q <= 1'b0;
         oc_q   <= 1'b0;
         tun_q  <= 1'b0;
         ov_q   <= 1'b0;
         lc_q   <= 1'b0;
      end else begin
         if (wake_s[1] == wake_s[2]) wake_q <= wake_s[2];
         if (oc_s[1] == oc_s[2])     oc_q   <= oc_s[2];
         if (tun_s[1] == tun_s[2])   tun_q  <= tun_s[2];
         if (ov_s[1] == ov_s[2])     ov_q   <= ov_s[2];
         if (lc_s[1] == lc_s[2])     lc_q   <= lc_s[2];
      end
   end

   // the wake comparator pin itself encodes the variant level
   pcp_pkg::pcp_mode_t mode;
   logic sleep_req;
   assign sleep_req = control_reg[pcp_pkg::SLEEP_BIT];
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode <= pcp_pkg::PCP_SLEEP;
      end else begin
         case (mode)
            pcp_pkg::PCP_SLEEP: begin
               if (wake_q) mode <= pcp_pkg::PCP_WAKE;
            end
            pcp_pkg::PCP_WAKE:  mode <= pcp_pkg::PCP_RUN;
            pcp_pkg::PCP_RUN:   if (sleep_req) mode <= pcp_pkg::PCP_SLEEP;
            default:            mode <= pcp_pkg::PCP_SLEEP;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) normal_mode <= 1'b0;
      else normal_mode <= (mode == pcp_pkg::PCP_RUN) && !sleep_req;
   end

   // calibration window: informational; the controller must honour it
   logic [CW-1:0] cal_cnt;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cal_cnt  <= '0;
         cal_busy <= 1'b0;
      end else if (mode == pcp_pkg::PCP_WAKE) begin
         cal_cnt  <= CW'(CAL_CYCLES);
         cal_busy <= 1'b1;
      end else if (cal_cnt != '0) begin
         cal_cnt  <= cal_cnt - 1'b1;
         cal_busy <= (cal_cnt != CW'(1));
      end else begin
         cal_busy <= 1'b0;
      end
   end

   // nonvolatile shadow; its reset value stands for the factory image
   logic [15:0] shadow;
   logic        wren_latch;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         shadow     <= CFG_DEF;
         wren_latch <= 1'b0;
      end else begin
         if (write_enable_cmd) wren_latch <= 1'b1;
         else if (eeprom_write_cmd) wren_latch <= 1'b0;
         if (eeprom_write_cmd && wren_latch)
            shadow <= pack_configuration;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pack_configuration <= CFG_DEF;
      end else if (mode == pcp_pkg::PCP_WAKE) begin
         pack_configuration <= shadow;
      end else if (cfg_wr && mode == pcp_pkg::PCP_RUN) begin
         // low six bits are ignored and read as zero
         pack_configuration <= {cfg_wdata[15:6], 6'h00};
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) control_reg <= pcp_pkg::CTRL_RST;
      else if (mode != pcp_pkg::PCP_RUN)
         control_reg <= pcp_pkg::CTRL_RST;
      else if (ctrl_wr) control_reg <= ctrl_wdata;
   end

   // fet gates: a zero control bit means the fet is held off
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         charge_fet_off    <= 1'b1;
         discharge_fet_off <= 1'b1;
      end else begin
         charge_fet_off    <= !control_reg[pcp_pkg::CHG_FET_BIT] ||
                              (mode != pcp_pkg::PCP_RUN);
         discharge_fet_off <= !control_reg[pcp_pkg::DSG_FET_BIT] ||
                              (mode != pcp_pkg::PCP_RUN);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) status_bits <= 3'h1;
      else begin
         status_bits[pcp_pkg::STAT_OC_BIT] <= oc_q || !tun_q;
         status_bits[1] <= 1'b0;
         status_bits[pcp_pkg::STAT_CE_BIT] <= ov_q ||
            (!pack_configuration[pcp_pkg::CE_OFF_BIT] && lc_q);
      end
   end

   // decoded fields feed the analog threshold selectors
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         overcharge_threshold_sel    <= CFG_DEF[15:14];
         undervoltage_threshold_sel  <= CFG_DEF[13:12];
         overcurrent_threshold_sel   <= CFG_DEF[11:10];
         charge_enable_threshold_sel <= CFG_DEF[9:8];
         cell_count_select           <= CFG_DEF[7];
         charge_enable_disable       <= CFG_DEF[6];
      end else begin
         overcharge_threshold_sel    <= pack_configuration[15:14];
         undervoltage_threshold_sel  <= pack_configuration[13:12];
         overcurrent_threshold_sel   <= pack_configuration[11:10];
         charge_enable_threshold_sel <= pack_configuration[9:8];
         cell_count_select           <= pack_configuration[7];
         charge_enable_disable       <= pack_configuration[6];
      end
   end

   a_sleep_until_wake: assert property (
      (mode == pcp_pkg::PCP_SLEEP && !wake_q) |=> mode != pcp_pkg::PCP_RUN)
      else $error("left sleep without wake level");
   a_ctrl_clear_wake: assert property (
      (mode == pcp_pkg::PCP_WAKE) |=> control_reg == 16'h0000)
      else $error("control register not cleared on wake");
   a_fets_off_zero: assert property (
      (control_reg[11:10] == 2'b00) |=> (charge_fet_off && discharge_fet_off))
      else $error("fet driven on with control bits zero");
   a_low_bits_zero: assert property (
      cfg_wr && mode == pcp_pkg::PCP_RUN |=> pack_configuration[5:0] == 6'h00)
      else $error("ignored configuration bits stored");
   a_reload_shadow: assert property (
      (mode == pcp_pkg::PCP_WAKE) |=> pack_configuration == $past(shadow))
      else $error("configuration not reloaded from shadow");
   a_stat_oc: assert property (
      (oc_q || !tun_q) |=> status_bits[0])
      else $error("status bit 0 low with over-current or untuned");
   a_stat_ce: assert property (
      (pack_configuration[6] && !ov_q) |=> !status_bits[2])
      else $error("status bit 2 set without over-charge");
   a_field_ov: assert property (
      ##1 overcharge_threshold_sel == $past(pack_configuration[15:14]))
      else $error("over-charge field not forwarded");
endmodule
`default_nettype wire

// file: include/pcp_pkg.sv
/*
 pcp_pkg: constants for the pack configuration and power-up block.
 assumes a 40 MHz core clock; analog comparisons arrive as pins.
*/
`default_nettype none
package pcp_pkg;
   localparam int CLK_HZ = 40_000_000;
   // configuration register field positions
   localparam int CE_OFF_BIT  = 6;
   localparam int CELL4_BIT   = 7;
   localparam int CE_THR_LSB  = 8;
   localparam int OC_THR_LSB  = 10;
   localparam int UV_THR_LSB  = 12;
   localparam int OV_THR_LSB  = 14;
   localparam int CFG_LIVE_LSB = 6;
   // defaults after reload
   localparam logic [15:0] CFG_RST_4CELL = 16'h30C0;
   localparam logic [15:0] CFG_RST_3CELL = 16'h0040;
   localparam logic [15:0] CTRL_RST      = 16'h0000;
   // control register bits
   localparam int CHG_FET_BIT = 10;
   localparam int DSG_FET_BIT = 11;
   localparam int SLEEP_BIT   = 7;
   // status bits
   localparam int STAT_OC_BIT = 0;
   localparam int STAT_CE_BIT = 2;
   // calibration guard: extra time after the longer detect delay
   localparam int GUARD_MS = 200;
   localparam int GUARD_CYC = GUARD_MS * (CLK_HZ / 1000);
   typedef enum logic [1:0] {
      PCP_SLEEP = 2'b00,
      PCP_WAKE  = 2'b01,
      PCP_RUN   = 2'b10
   } pcp_mode_t;
endpackage
`default_nettype wire

// file: verif/pcp_mcu_model.sv
/* pcp_mcu_model: host controller that issues register strobes.
 assumes bench ops change at the falling edge by nonblocking update. */
`timescale 1ns/1ps
`default_nettype none
module pcp_mcu_model (
   input  wire logic        core_clk,
   input  wire logic        normal_mode,
   input  wire logic        cal_busy,
   input  wire logic [2:0]  op,
   input  wire logic [15:0] op_data,
   output logic             cfg_wr,
   output logic             ctrl_wr,
   output logic [15:0]      wdata,
   output logic             wren,
   output logic             eewr
);
   // lines stay low until the device runs
   always_ff @(negedge core_clk) begin
      cfg_wr  <= normal_mode && op == 3'h1;
      ctrl_wr <= normal_mode && op == 3'h2;
      wren    <= normal_mode && op == 3'h3;
      eewr    <= normal_mode && op == 3'h4;
   end
   // fet turn-on bits masked while calibrating
   always_ff @(negedge core_clk) begin
      wdata <= (op == 3'h2 && cal_busy) ? (op_data & 16'hF3FF) : op_data;
   end
endmodule
`default_nettype wire

// file: verif/pcp_config_tb.sv
/* pcp_config_tb: random and corner tests of the pack config block.
 assumes a short calibration window set by parameter. */
`timescale 1ns/1ps
`default_nettype none
module pcp_config_tb;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        wake = 1'b0;
   logic        oc = 1'b0, tuned = 1'b0, ovf = 1'b0, low = 1'b0;
   logic [2:0]  op = 3'h0;
   logic [15:0] op_data = 16'h0000;
   logic        cfg_wr, ctrl_wr, wren, eewr, nm, cal;
   logic        chg_off, dsg_off, ccs, ced;
   logic [15:0] wdata, cfg, ctrl, w, keep;
   logic [2:0]  st;
   logic [1:0]  ovs, uvs, ocs, ces;
   logic [15:0] cfg3;
   logic [1:0]  uvs3;
   localparam int CAL = 20;
   int          n;
   logic [31:0] seed = 32'h69BA;
   int          err_count = 0;
   int          num_checks = 0;
   always #12.5 core_clk = ~core_clk;
   pcp_mcu_model i_mcu (.core_clk(core_clk), .normal_mode(nm),
      .cal_busy(cal), .op(op), .op_data(op_data), .cfg_wr(cfg_wr),
      .ctrl_wr(ctrl_wr), .wdata(wdata), .wren(wren), .eewr(eewr));
   pcp_config #(.CAL_CYCLES(CAL)) i_dut (.core_clk(core_clk),
      .arst_n(arst_n), .wake_supply_level(wake), .cfg_wr(cfg_wr),
      .cfg_wdata(wdata), .ctrl_wr(ctrl_wr), .ctrl_wdata(wdata),
      .write_enable_cmd(wren), .eeprom_write_cmd(eewr),
      .overcurrent_active(oc), .regulator_tuned(tuned),
      .overcharge_flag(ovf), .lowcell_detect(low), .normal_mode(nm),
      .cal_busy(cal), .pack_configuration(cfg), .control_reg(ctrl),
      .charge_fet_off(chg_off), .discharge_fet_off(dsg_off),
      .status_bits(st), .overcharge_threshold_sel(ovs),
      .undervoltage_threshold_sel(uvs), .overcurrent_threshold_sel(ocs),
      .charge_enable_threshold_sel(ces), .cell_count_select(ccs),
      .charge_enable_disable(ced));
   // three-cell variant shares all traffic; only its defaults differ
   pcp_config #(.FOUR_CELL(1'b0), .CAL_CYCLES(CAL)) i_dut3 (
      .core_clk(core_clk), .arst_n(arst_n), .wake_supply_level(wake),
      .cfg_wr(cfg_wr), .cfg_wdata(wdata), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(wdata), .write_enable_cmd(wren), .eeprom_write_cmd(eewr),
      .overcurrent_active(oc), .regulator_tuned(tuned),
      .overcharge_flag(ovf), .lowcell_detect(low), .normal_mode(),
      .cal_busy(), .pack_configuration(cfg3), .control_reg(),
      .charge_fet_off(), .discharge_fet_off(), .status_bits(),
      .overcharge_threshold_sel(), .undervoltage_threshold_sel(uvs3),
      .overcurrent_threshold_sel(), .charge_enable_threshold_sel(),
      .cell_count_select(), .charge_enable_disable());
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [2:0] exp_st(logic ce_off);
      return {ce_off ? ovf : (ovf | low), 1'b0, oc | ~tuned};
   endfunction
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic mcu(logic [2:0] o, logic [15:0] d);
      @(negedge core_clk);
      op <= o;
      op_data <= d;
      @(negedge core_clk);
      op <= 3'h0;
      repeat (3) @(negedge core_clk);
   endtask
   // bounded wait on normal_mode (sel 0) or cal_busy (sel 1)
   task automatic wait_sig(int sel, logic v);
      for (int i = 0; i < 200; i++) begin
         if ((sel == 1 ? cal : nm) === v)
            return;
         @(negedge core_clk);
      end
      err_count++;
      end_sim();
   endtask
   initial begin
      repeat (12) @(negedge core_clk);
      arst_n <= 1'b1;
      chk("cfg_rst", cfg, pcp_pkg::CFG_RST_4CELL);
      chk("cfg_rst3", cfg3, pcp_pkg::CFG_RST_3CELL);
      chk("uv_rst", uvs, 16'h0003);
      chk("uv_rst3", uvs3, 16'h0000);
      chk("fets_rst", {chg_off, dsg_off}, 2'b11);
      repeat (20) @(negedge core_clk);
      chk("asleep", nm, 1'b0);
      wake <= 1'b1;
      wait_sig(0, 1'b1);
      chk("ctrl_wake", ctrl, pcp_pkg::CTRL_RST);
      chk("cfg_wake", cfg, pcp_pkg::CFG_RST_4CELL);
      chk("cal_busy", cal, 1'b1);
      // a turn-on asked for inside the window must not reach the fets
      mcu(3'h2, 16'h0C00);
      chk("fets_cal", {chg_off, dsg_off}, 2'b11);
      for (int i = 0; i < 24; i++) begin
         w = 16'(rnd());
         if (i < 2)
            w = (i == 1) ? 16'hFFFF : 16'h0000;
         mcu(3'h1, w);
         chk("cfg", cfg, {w[15:6], 6'h00});
         chk("fld_hi", {ovs, uvs, ocs}, w[15:10]);
         chk("fld_lo", {ces, ccs, ced}, w[9:6]);
         {oc, tuned, ovf, low} <= 4'(rnd());
         repeat (8) @(negedge core_clk);
         chk("status", st, exp_st(w[6]));
      end
      wait_sig(1, 1'b0);
      // healthy pack: tuned, no fault, before the fets are enabled
      {oc, tuned, ovf, low} <= 4'h4;
      repeat (8) @(negedge core_clk);
      chk("stat_clear", st, 16'h0000);
      mcu(3'h2, 16'h0C00);
      chk("fets_on", {chg_off, dsg_off}, 2'b00);
      mcu(3'h2, 16'h0000);
      chk("fets_off", {chg_off, dsg_off}, 2'b11);
      keep = 16'(rnd()) & 16'hFFC0;
      mcu(3'h1, keep);
      mcu(3'h3, 16'h0000);
      mcu(3'h4, 16'h0000);
      // supply must be seen low before sleep, or the level re-wakes it
      wake <= 1'b0;
      mcu(3'h1, ~keep);
      mcu(3'h2, 16'h0C80);
      repeat (20) @(negedge core_clk);
      chk("sleep", nm, 1'b0);
      chk("fets_sleep", {chg_off, dsg_off}, 2'b11);
      wake <= 1'b1;
      wait_sig(1, 1'b1);
      n = 0;
      while (cal === 1'b1 && n < 100) begin
         n++;
         @(negedge core_clk);
      end
      chk("cal_len", 16'(n), 16'(CAL));
      wait_sig(0, 1'b1);
      chk("reload", cfg, keep);
      chk("ctrl_clr", ctrl, 16'h0000);
      chk("fets_wake", {chg_off, dsg_off}, 2'b11);
      end_sim();
   end
endmodule
`default_nettype wire
